// [rx_irq_map.svh]
/*
 Register indices, field positions and reset values of the receive-port
 interrupt enable block. Assumes inclusion by the package and the design.
*/
`ifndef RX_IRQ_MAP_SVH
`define RX_IRQ_MAP_SVH

// Register indices; byte address is four times the index
`define IDX_EN_HI 8'hD8
`define IDX_EN_LO 8'hD9
`define IDX_STS_HI 8'hDA
`define IDX_STS_LO 8'hDB
`define IDX_CLR_HI 8'hDC
`define IDX_CLR_LO 8'hDD
`define IDX_FLOOR 8'hDE
`define IDX_NONE 8'hFF

// Enable high fields
`define BIT_ENC 2
`define BIT_SEQ 1
`define BIT_CRC 0
// Enable low fields
`define BIT_LEN 6
`define BIT_CNT 5
`define BIT_BUF 4
`define BIT_PAR 2
`define BIT_PASS 1
`define BIT_LOCK 0
// Floor register fields
`define FLOOR_MSB 3
`define FLOOR_LSB 0
`define BIT_FLOOR_EN 4

`define EN_HI_MASK 8'h07
`define EN_LO_USED 8'h77
`define STS1_MASK_HI 8'h03
`define STS2_MASK_HI 8'h04
`define STS1_MASK_LO 8'h07
`define STS2_MASK_LO 8'h70

`define RST_EN 8'h00
`define RST_STS 8'h00
`define RST_FLOOR 4'h8

`endif

// [rx_irq_pkg.sv]
/*
 Types of the receive-port interrupt enable block.
 Assumes the register map header is on the include path.
*/
`include "rx_irq_map.svh"

package rx_irq_pkg;

    typedef struct packed {
        logic encode_error_flag;
        logic ctrl_chan_sequence_flag;
        logic ctrl_chan_crc_flag;
        logic line_length_changed_flag;
        logic line_count_changed_flag;
        logic buffer_overflow_flag;
        logic parity_error_flag;
        logic port_valid_changed_flag;
        logic lock_changed_flag;
    } rx_event_type;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_WRITE = 2'h1,
        BUS_READ = 2'h3,
        BUS_READ_OUT = 2'h2
    } bus_state_type;

    typedef struct packed {
        logic [7:0] index;
    } addr_phase_type;

endpackage : rx_irq_pkg

// [rx_port_interrupt_enables.sv]
/*
 AHB-Lite register slave holding the receive-port interrupt enables,
 sticky status, clear registers and the equalizer floor start value.
 Assumes receive events arrive as one-cycle pulses on hclk, and that the
 status-register read strobes come from logic on the same clock.
*/
// The AHB-Lite register port was left to the implementer.
// What this block does
// - Floor enabled: equalizer starts at floor value
// - Encode error interrupts when its enable set
// - Control-channel sequence error interrupts when enabled
// - Control-channel CRC error interrupts when enabled
// - Line length change interrupts when enabled
// - Line count change interrupts when enabled
// - Receive buffer overflow interrupts when enabled
// - Parity error interrupts when enabled
// - Port valid change interrupts when enabled
// - Lock status change interrupts when enabled
// - Status register read clears its pending conditions
`timescale 1ns/1ps
`include "rx_irq_map.svh"

module rx_port_interrupt_enables (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire rx_irq_pkg::rx_event_type rx_events,
    input wire logic status_one_read,
    input wire logic status_two_read,
    output logic irq,
    output logic eq_floor_enable,
    output logic [3:0] eq_start_value
);

    rx_irq_pkg::bus_state_type state_ff;
    rx_irq_pkg::addr_phase_type aphase_ff;
    logic [31:0] hrdata_ff;
    logic [7:0] en_hi_ff;
    logic [7:0] en_lo_ff;
    logic [7:0] sts_hi_ff;
    logic [7:0] sts_lo_ff;
    logic [3:0] floor_ff;
    logic floor_en_ff;
    logic [3:0] start_ff;
    logic accept;
    logic wr_en;
    logic [7:0] wr_byte;
    logic [7:0] set_hi;
    logic [7:0] set_lo;
    logic [7:0] clr_hi;
    logic [7:0] clr_lo;
    logic [7:0] nxt_sts_hi;
    logic [7:0] nxt_sts_lo;

    // Full address check so aliases above the map read as unmapped
    function automatic logic [7:0] index_of(input logic [31:0] addr);
        if (addr[31:10] == 22'h0 && addr[1:0] == 2'h0)
        begin
            index_of = addr[9:2];
        end
        else
        begin
            index_of = `IDX_NONE;
        end
    endfunction : index_of

    function automatic logic [7:0] read_mux(input logic [7:0] idx);
        case (idx)
            `IDX_EN_HI: read_mux = en_hi_ff & `EN_HI_MASK;
            `IDX_EN_LO: read_mux = en_lo_ff;
            `IDX_STS_HI: read_mux = sts_hi_ff;
            `IDX_STS_LO: read_mux = sts_lo_ff;
            `IDX_FLOOR: read_mux = {3'h0, floor_en_ff, floor_ff};
            default: read_mux = 8'h00;
        endcase
    endfunction : read_mux

    assign accept = ce && hsel && htrans[1] && hready;
    assign wr_en = ce && (state_ff == rx_irq_pkg::BUS_WRITE);
    assign wr_byte = hwdata[7:0];
    // Reads take one wait state so a write just before is seen
    assign hreadyout = ce && (state_ff != rx_irq_pkg::BUS_READ);
    assign hresp = 1'b0;
    assign hrdata = hrdata_ff;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= rx_irq_pkg::BUS_IDLE;
        end
        else if (ce)
        begin
            case (state_ff)
                rx_irq_pkg::BUS_READ: state_ff <= rx_irq_pkg::BUS_READ_OUT;
                default:
                begin
                    if (accept && hwrite)
                    begin
                        state_ff <= rx_irq_pkg::BUS_WRITE;
                    end
                    else if (accept)
                    begin
                        state_ff <= rx_irq_pkg::BUS_READ;
                    end
                    else
                    begin
                        state_ff <= rx_irq_pkg::BUS_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            aphase_ff <= '0;
        end
        else if (accept)
        begin
            aphase_ff.index <= index_of(haddr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_ff <= 32'h0;
        end
        else if (ce && state_ff == rx_irq_pkg::BUS_READ)
        begin
            hrdata_ff <= {24'h0, read_mux(aphase_ff.index)};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_hi_ff <= `RST_EN;
            en_lo_ff <= `RST_EN;
        end
        else if (wr_en && aphase_ff.index == `IDX_EN_HI)
        begin
            en_hi_ff <= wr_byte & `EN_HI_MASK;
        end
        else if (wr_en && aphase_ff.index == `IDX_EN_LO)
        begin
            en_lo_ff <= wr_byte;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            floor_ff <= `RST_FLOOR;
            floor_en_ff <= 1'b0;
        end
        else if (wr_en && aphase_ff.index == `IDX_FLOOR)
        begin
            floor_ff <= wr_byte[`FLOOR_MSB:`FLOOR_LSB];
            floor_en_ff <= wr_byte[`BIT_FLOOR_EN];
        end
    end

    // Starting point handed to the equalizer, zero unless floor is on
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_ff <= 4'h0;
        end
        else if (ce)
        begin
            start_ff <= floor_en_ff ? floor_ff : 4'h0;
        end
    end

    assign eq_floor_enable = floor_en_ff;
    assign eq_start_value = start_ff;

    always_comb
    begin
        set_hi = 8'h00;
        set_lo = 8'h00;
        set_hi[`BIT_ENC] = rx_events.encode_error_flag;
        set_hi[`BIT_SEQ] = rx_events.ctrl_chan_sequence_flag;
        set_hi[`BIT_CRC] = rx_events.ctrl_chan_crc_flag;
        set_lo[`BIT_LEN] = rx_events.line_length_changed_flag;
        set_lo[`BIT_CNT] = rx_events.line_count_changed_flag;
        set_lo[`BIT_BUF] = rx_events.buffer_overflow_flag;
        set_lo[`BIT_PAR] = rx_events.parity_error_flag;
        set_lo[`BIT_PASS] = rx_events.port_valid_changed_flag;
        set_lo[`BIT_LOCK] = rx_events.lock_changed_flag;
        clr_hi = 8'h00;
        clr_lo = 8'h00;
        if (status_one_read)
        begin
            clr_hi = clr_hi | `STS1_MASK_HI;
            clr_lo = clr_lo | `STS1_MASK_LO;
        end
        if (status_two_read)
        begin
            clr_hi = clr_hi | `STS2_MASK_HI;
            clr_lo = clr_lo | `STS2_MASK_LO;
        end
        if (wr_en && aphase_ff.index == `IDX_CLR_HI)
        begin
            clr_hi = clr_hi | wr_byte;
        end
        if (wr_en && aphase_ff.index == `IDX_CLR_LO)
        begin
            clr_lo = clr_lo | wr_byte;
        end
        // A new event in the clearing cycle stays pending
        nxt_sts_hi = ((sts_hi_ff & ~clr_hi) | set_hi) & `EN_HI_MASK;
        nxt_sts_lo = ((sts_lo_ff & ~clr_lo) | set_lo) & `EN_LO_USED;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sts_hi_ff <= `RST_STS;
            sts_lo_ff <= `RST_STS;
        end
        else if (ce)
        begin
            sts_hi_ff <= nxt_sts_hi;
            sts_lo_ff <= nxt_sts_lo;
        end
    end

    // Level output; reserved enable bits never reach it
    assign irq = |(sts_hi_ff & en_hi_ff & `EN_HI_MASK)
        || |(sts_lo_ff & en_lo_ff & `EN_LO_USED);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_floor_start: assert property (
        ce && floor_en_ff |=> eq_start_value == $past(floor_ff))
        else $error("floor value not used as start");
    a_encode_irq: assert property (
        ce && rx_events.encode_error_flag && en_hi_ff[`BIT_ENC]
        && !(wr_en && aphase_ff.index == `IDX_EN_HI) |=> irq)
        else $error("encode error raised no interrupt");
    a_sequence_irq: assert property (
        ce && rx_events.ctrl_chan_sequence_flag
        |=> sts_hi_ff[`BIT_SEQ] && (en_hi_ff[`BIT_SEQ] -> irq))
        else $error("sequence error not latched");
    a_crc_irq: assert property (
        ce && rx_events.ctrl_chan_crc_flag && en_hi_ff[`BIT_CRC]
        && !(wr_en && aphase_ff.index == `IDX_EN_HI) |=> irq)
        else $error("crc error enabled but no interrupt");
    a_length_irq: assert property (
        ce && rx_events.line_length_changed_flag
        |=> sts_lo_ff[`BIT_LEN] && (en_lo_ff[`BIT_LEN] -> irq))
        else $error("line length change lost");
    a_count_irq: assert property (
        ce && rx_events.line_count_changed_flag && en_lo_ff[`BIT_CNT]
        && !(wr_en && aphase_ff.index == `IDX_EN_LO) |=> irq)
        else $error("line count change gave no interrupt");
    a_buffer_irq: assert property (
        ce && rx_events.buffer_overflow_flag ##1 en_lo_ff[`BIT_BUF]
        |-> irq)
        else $error("buffer overflow gave no interrupt");
    a_parity_irq: assert property (
        ce && rx_events.parity_error_flag && en_lo_ff[`BIT_PAR]
        && !(wr_en && aphase_ff.index == `IDX_EN_LO) |=> irq)
        else $error("parity error gave no interrupt");
    a_pass_irq: assert property (
        ce && rx_events.port_valid_changed_flag
        |=> sts_lo_ff[`BIT_PASS] [*1] ##0 (en_lo_ff[`BIT_PASS] -> irq))
        else $error("port valid change gave no interrupt");
    a_lock_irq: assert property (
        ce && rx_events.lock_changed_flag && en_lo_ff[`BIT_LOCK]
        && !(wr_en && aphase_ff.index == `IDX_EN_LO) |=> irq)
        else $error("lock change gave no interrupt");
    a_read_clear: assert property (
        ce && status_one_read && !rx_events.lock_changed_flag
        && !rx_events.ctrl_chan_crc_flag
        |=> !sts_lo_ff[`BIT_LOCK] && !sts_hi_ff[`BIT_CRC])
        else $error("status read did not clear condition");
    a_irq_gated: assert property (
        ((en_hi_ff & `EN_HI_MASK) == 8'h00
        && (en_lo_ff & `EN_LO_USED) == 8'h00) |-> !irq)
        else $error("interrupt raised with nothing enabled");
    a_read_wait: assert property (
        ce && state_ff == rx_irq_pkg::BUS_READ
        |-> !hreadyout ##1 (ce -> hreadyout))
        else $error("read wait state wrong");

endmodule : rx_port_interrupt_enables

// [tb_rx_port_interrupt_enables.sv]
/*
 Self-checking testbench of the receive-port interrupt enable block.
 Assumes the register map header and the package are compiled first.
*/
`timescale 1ns/1ps
`include "rx_irq_map.svh"

module tb_rx_port_interrupt_enables;
    logic hclk;
    logic hresetn;
    logic ce;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    rx_irq_pkg::rx_event_type rx_events;
    logic status_one_read;
    logic status_two_read;
    logic irq;
    logic eq_floor_enable;
    logic [3:0] eq_start_value;
    logic [31:0] rdata;
    int errors;
    int n_compared;
    localparam int P_IRQ = 0;
    localparam int P_FLOOR_EN = 1;
    localparam int P_START = 2;
    localparam int P_READY = 3;
    localparam int P_HRESP = 4;

    rx_port_interrupt_enables DUT (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(3'h2),
        .hwdata(hwdata),
        .hready(hreadyout),
        .hrdata(hrdata),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .rx_events(rx_events),
        .status_one_read(status_one_read),
        .status_two_read(status_two_read),
        .irq(irq),
        .eq_floor_enable(eq_floor_enable),
        .eq_start_value(eq_start_value)
    );

    always #20 hclk = ~hclk;

    task close_out;
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    // Picks the pin mid-cycle, so outputs have settled when looked at
    task chk_pin(input int which, input logic [31:0] exp);
        logic [31:0] got;
        @(negedge hclk);
        case (which)
            P_IRQ: got = {31'h0, irq};
            P_FLOOR_EN: got = {31'h0, eq_floor_enable};
            P_START: got = {28'h0, eq_start_value};
            P_READY: got = {31'h0, hreadyout};
            default: got = {31'h0, hresp};
        endcase
        chk_reg(got, exp);
        @(posedge hclk);
    endtask : chk_pin

    // Ready and read data taken at the rising edge, before it updates them
    task wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge hclk);
        end
        if (n >= 20)
        begin
            errors++;
            close_out();
        end
        rdata = hrdata;
    endtask : wait_ready

    task bus_write(input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= 1'b1;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_ready();
    endtask : bus_write

    task bus_read(input logic [7:0] idx, output logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= 2'h2;
        hwrite <= 1'b0;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        wait_ready();
        v = rdata;
    endtask : bus_read

    task pulse_event(input int i);
        rx_events <= rx_irq_pkg::rx_event_type'(9'h001 << i);
        @(posedge hclk);
        rx_events <= rx_irq_pkg::rx_event_type'(9'h000);
        @(posedge hclk);
    endtask : pulse_event

    task strobe(input logic two);
        if (two)
            status_two_read <= 1'b1;
        else
            status_one_read <= 1'b1;
        @(posedge hclk);
        status_one_read <= 1'b0;
        status_two_read <= 1'b0;
        @(posedge hclk);
    endtask : strobe

    initial
    begin
        logic hi;
        logic two;
        logic [7:0] m;
        logic [7:0] en_idx;
        logic [7:0] sts_idx;
        logic [7:0] clr_idx;
        hclk = 1'b0;
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        rx_events = rx_irq_pkg::rx_event_type'(9'h000);
        status_one_read = 1'b0;
        status_two_read = 1'b0;
        errors = 0;
        n_compared = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk_pin(P_IRQ, 1'b0);
        chk_pin(P_FLOOR_EN, 1'b0);
        chk_pin(P_START, 32'h00000000);
        bus_read(`IDX_EN_HI, rdata);
        chk_reg(rdata, 32'h00000000);
        bus_read(`IDX_EN_LO, rdata);
        chk_reg(rdata, 32'h00000000);
        bus_read(`IDX_FLOOR, rdata);
        chk_reg(rdata, 32'h00000008);
        chk_pin(P_HRESP, 1'b0);
        bus_write(`IDX_EN_HI, 8'hFF);
        bus_read(`IDX_EN_HI, rdata);
        chk_reg(rdata, 32'h00000007);
        bus_write(`IDX_EN_LO, 8'hFF);
        bus_read(`IDX_EN_LO, rdata);
        chk_reg(rdata, 32'h000000FF);
        bus_write(`IDX_NONE, 8'hFF);
        bus_read(`IDX_NONE, rdata);
        chk_reg(rdata, 32'h00000000);
        bus_read(`IDX_CLR_HI, rdata);
        chk_reg(rdata, 32'h00000000);
        // Event order in the struct, lsb upward: lock .. encode
        for (int i = 0; i < 9; i++)
        begin
            hi = (i >= 6);
            m = 8'h01 << (hi ? i - 6 : (i >= 3 ? i + 1 : i));
            two = (i == 8) || (i >= 3 && i <= 5);
            en_idx = hi ? `IDX_EN_HI : `IDX_EN_LO;
            sts_idx = hi ? `IDX_STS_HI : `IDX_STS_LO;
            clr_idx = hi ? `IDX_CLR_HI : `IDX_CLR_LO;
            bus_write(`IDX_EN_HI, 8'h00);
            bus_write(`IDX_EN_LO, 8'h00);
            pulse_event(i);
            chk_pin(P_IRQ, 1'b0);
            bus_read(sts_idx, rdata);
            chk_reg(rdata, {24'h0, m});
            bus_write(en_idx, m);
            chk_pin(P_IRQ, 1'b1);
            strobe(~two);
            chk_pin(P_IRQ, 1'b1);
            strobe(two);
            chk_pin(P_IRQ, 1'b0);
            pulse_event(i);
            chk_pin(P_IRQ, 1'b1);
            bus_write(clr_idx, m);
            chk_pin(P_IRQ, 1'b0);
            bus_read(sts_idx, rdata);
            chk_reg(rdata, 32'h00000000);
        end
        // Clock enable low: bus stalls and events are dropped
        ce <= 1'b0;
        chk_pin(P_READY, 1'b0);
        pulse_event(0);
        ce <= 1'b1;
        bus_read(`IDX_STS_LO, rdata);
        chk_reg(rdata, 32'h00000000);
        bus_write(`IDX_FLOOR, 8'h1A);
        chk_pin(P_FLOOR_EN, 1'b1);
        chk_pin(P_START, 32'h0000000A);
        bus_write(`IDX_FLOOR, 8'h05);
        chk_pin(P_FLOOR_EN, 1'b0);
        chk_pin(P_START, 32'h00000000);
        bus_read(`IDX_FLOOR, rdata);
        chk_reg(rdata, 32'h00000005);
        close_out();
    end
endmodule : tb_rx_port_interrupt_enables
